// *** src/irq_unit_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef IRQ_UNIT_MAP_SVH
`define IRQ_UNIT_MAP_SVH
`define ADDR_MISC_OPTION_CTRL 8'h94
`define ADDR_AUX_EVENT_FLAGS 8'h95
`define ADDR_PORT1_WAKE_ENABLE 8'h96
`define ADDR_IRQ_ENABLE_MAIN 8'hA8
`define ADDR_IRQ_ENABLE_AUX 8'hA9
`define ADDR_PRIORITY_LOW 8'hB8
`define ADDR_PRIORITY_HIGH 8'hB9
`define ADDR_PRIORITY_AUX_LOW 8'hBA
`define ADDR_PRIORITY_AUX_HIGH 8'hBB
`define ADDR_SRC_PENDING 8'hF0
`define ADDR_SRC_MASK 8'hF1
`define RST_MISC_OPTION_CTRL 8'hC1
`define RST_PORT1_WAKE_ENABLE 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_SRC_MASK 8'h00
`define BIT_TOUCH_FLAG 3
`define BIT_EXT2_FLAG 2
`define BIT_PORT1_FLAG 1
`define BIT_RTC_FLAG 0
`define CLR_TOUCH_CODE 8'hF7
`define CLR_EXT2_CODE 8'hFB
`define CLR_PORT1_CODE 8'hFD
`define CLR_RTC_CODE 8'hFE
`define BIT_GLOBAL_EN 7
`define BIT_TIMER2_EN 5
`define BIT_SERIAL_EN 4
`define BIT_TIMER1_EN 3
`define BIT_EXT1_EN 2
`define BIT_TIMER0_EN 1
`define BIT_EXT0_EN 0
`define BIT_SPI_EN 4
`define BIT_TOUCH_EN 3
`define BIT_EXT2_EN 2
`define BIT_PORT1_EN 1
`define BIT_RTC_EN 0
`define UNLOCK_HI 7
`define UNLOCK_LO 5
`define UNLOCK_CODE 3'h5
`define RTC_COUNT_BITS 23
`define RTC_CYC_32K 32768
`define RTC_CYC_16K 16384
`define RTC_CYC_8K 8192
`define SLOW_CLOCK_HZ 32768
`define SYS_CLOCK_HZ 25000000
`endif

// *** src/irq_unit_pkg.sv ***
// Types shared by the interrupt flag and enable unit
package irq_unit_pkg;
    typedef enum logic [3:0] {
        SRC_EXT0, SRC_TIMER0, SRC_EXT1, SRC_TIMER1, SRC_SERIAL, SRC_TIMER2,
        SRC_RTC, SRC_PORT1, SRC_EXT2, SRC_TOUCH, SRC_SPI, SRC_NONE
    } src_t;
    typedef logic [1:0] rate_sel_t;
endpackage : irq_unit_pkg

// *** src/rtc_tick_if.sv ***
// Carries the slow tick and timer event between the timer and the top
`timescale 1ns/1ps
interface rtc_tick_if;
    logic slow_tick;
    irq_unit_pkg::rate_sel_t rate_sel;
    logic timer_event;
    modport timer (input slow_tick, input rate_sel, output timer_event);
    modport owner (output slow_tick, output rate_sel, input timer_event);
endinterface : rtc_tick_if

// *** src/rtc_timer.sv ***
// Real-time timer: 23-bit count of slow ticks with selectable event rate
`timescale 1ns/1ps
`include "irq_unit_map.svh"
module rtc_timer #(
    parameter int COUNT_BITS = `RTC_COUNT_BITS
) (
    input wire logic clock,
    input wire logic rst_n,
    rtc_tick_if.timer tick
);
    logic [COUNT_BITS-1:0] count;
    logic [COUNT_BITS-1:0] next_count;
    logic hit;

    assign next_count = count + {{(COUNT_BITS-1){1'b0}}, 1'b1};

    always_comb
    begin
        unique case (tick.rate_sel)
            2'h1: hit = next_count[14:0] == 15'h0000;
            2'h2: hit = next_count[13:0] == 14'h0000;
            2'h3: hit = next_count[12:0] == 13'h0000;
            2'h0: hit = next_count == '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            count <= '0;
        else if (tick.slow_tick)
            count <= next_count;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            tick.timer_event <= 1'b0;
        else
            tick.timer_event <= tick.slow_tick && hit;
    end
endmodule : rtc_timer

// *** src/slow_tick_gen.sv ***
// Divides the system clock into a slow-clock enable pulse
`timescale 1ns/1ps
`include "irq_unit_map.svh"
module slow_tick_gen #(
    parameter int DIVIDE = `SYS_CLOCK_HZ / `SLOW_CLOCK_HZ
) (
    input wire logic clock,
    input wire logic rst_n,
    rtc_tick_if.owner tick
);
    logic [15:0] div;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            div <= 16'h0000;
            tick.slow_tick <= 1'b0;
        end
        else if (div == 16'(DIVIDE - 1))
        begin
            div <= 16'h0000;
            tick.slow_tick <= 1'b1;
        end
        else
        begin
            div <= div + 16'h0001;
            tick.slow_tick <= 1'b0;
        end
    end
endmodule : slow_tick_gen

// *** src/irq_flag_enable_wake_unit.sv ***
// Interrupt flags, enables, wake-up and self-programming unlock
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "irq_unit_map.svh"
module irq_flag_enable_wake_unit #(
    parameter int SLOW_DIVIDE = `SYS_CLOCK_HZ / `SLOW_CLOCK_HZ
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic touch_detect,
    input wire logic ext_pin2,
    input wire logic [7:0] port1_pins,
    input wire logic [5:0] core_flags,
    input wire logic vector_ack,
    input wire logic [3:0] vector_src,
    input wire logic in_stop_mode,
    input wire logic ext_pin0_event,
    input wire logic ext_pin1_event,
    output logic irq_request,
    output logic [3:0] irq_source,
    output logic [1:0] irq_priority,
    output logic wake_request,
    output logic selfprog_write_unlock,
    output logic auto_touch_scan,
    output logic irq
);
    logic [7:0] misc_option_ctrl;
    logic [3:0] aux_event_flags;
    logic [7:0] port1_wake_enable;
    logic [7:0] interrupt_enable_main;
    logic [7:0] interrupt_enable_aux;
    logic [5:0] priority_low_reg;
    logic [5:0] priority_high_reg;
    logic [4:0] priority_aux_low;
    logic [4:0] priority_aux_high;
    logic [10:0] src_pending;
    logic [10:0] src_mask;
    logic [10:0] src_flags;
    logic [10:0] src_enable;
    logic [10:0] src_active;
    logic [10:0] src_set;
    logic [3:0] event_set;
    logic [3:0] event_clear;
    logic ext2_prev;
    logic [7:0] port1_prev;
    logic auto_touch_mode;
    logic global_irq_enable;
    logic [3:0] next_source;
    logic [1:0] next_priority;
    logic next_request;
    logic wake_cond;
    logic wake_prev;

    rtc_tick_if tick_bus ();

    slow_tick_gen #(.DIVIDE(SLOW_DIVIDE)) u_div (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick_bus.owner)
    );

    rtc_timer u_rtc (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick_bus.timer)
    );

    function automatic logic wr(input logic [7:0] a);
        return reg_write && reg_addr == a;
    endfunction : wr

    function automatic logic [1:0] prio(input logic [4:0] idx);
        logic [1:0] p;
        p = 2'h0;
        if (idx < 5'd6)
            p = {priority_high_reg[idx[2:0]], priority_low_reg[idx[2:0]]};
        else if (idx < 5'd11)
            p = {priority_aux_high[3'(idx - 5'd6)], priority_aux_low[3'(idx - 5'd6)]};
        return p;
    endfunction : prio

    // Touch flag only counts while auto-scan mode is on (software driven bit)
    assign auto_touch_mode = misc_option_ctrl[5];
    assign tick_bus.rate_sel = misc_option_ctrl[1:0];
    assign global_irq_enable = interrupt_enable_main[`BIT_GLOBAL_EN];

    always_comb
    begin
        event_set = 4'h0;
        event_set[`BIT_TOUCH_FLAG] = touch_detect && auto_touch_mode;
        event_set[`BIT_EXT2_FLAG] = ext2_prev && !ext_pin2;
        event_set[`BIT_PORT1_FLAG] = |((port1_prev ^ port1_pins) & port1_wake_enable);
        event_set[`BIT_RTC_FLAG] = tick_bus.timer_event;
    end

    always_comb
    begin
        event_clear = 4'h0;
        if (wr(`ADDR_AUX_EVENT_FLAGS))
        begin
            event_clear[`BIT_TOUCH_FLAG] = reg_wdata == `CLR_TOUCH_CODE;
            event_clear[`BIT_EXT2_FLAG] = reg_wdata == `CLR_EXT2_CODE;
            event_clear[`BIT_PORT1_FLAG] = reg_wdata == `CLR_PORT1_CODE;
            event_clear[`BIT_RTC_FLAG] = reg_wdata == `CLR_RTC_CODE;
        end
        if (vector_ack)
        begin
            event_clear[`BIT_TOUCH_FLAG] |= vector_src == irq_unit_pkg::SRC_TOUCH;
            event_clear[`BIT_EXT2_FLAG] |= vector_src == irq_unit_pkg::SRC_EXT2;
            event_clear[`BIT_PORT1_FLAG] |= vector_src == irq_unit_pkg::SRC_PORT1;
            event_clear[`BIT_RTC_FLAG] |= vector_src == irq_unit_pkg::SRC_RTC;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ext2_prev <= 1'b1;
            port1_prev <= 8'hFF;
        end
        else
        begin
            ext2_prev <= ext_pin2;
            port1_prev <= port1_pins;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            aux_event_flags <= 4'h0;
        else
            aux_event_flags <= (aux_event_flags & ~event_clear) | event_set;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            misc_option_ctrl <= `RST_MISC_OPTION_CTRL;
            port1_wake_enable <= `RST_PORT1_WAKE_ENABLE;
            interrupt_enable_main <= `RST_IRQ_ENABLE;
            interrupt_enable_aux <= `RST_IRQ_ENABLE;
            priority_low_reg <= 6'h00;
            priority_high_reg <= 6'h00;
            priority_aux_low <= 5'h00;
            priority_aux_high <= 5'h00;
            src_mask <= 11'(`RST_SRC_MASK);
        end
        else
        begin
            if (wr(`ADDR_MISC_OPTION_CTRL))
                misc_option_ctrl <= reg_wdata;
            if (wr(`ADDR_PORT1_WAKE_ENABLE))
                port1_wake_enable <= reg_wdata;
            if (wr(`ADDR_IRQ_ENABLE_MAIN))
                interrupt_enable_main <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
            if (wr(`ADDR_IRQ_ENABLE_AUX))
                interrupt_enable_aux <= reg_wdata;
            if (wr(`ADDR_PRIORITY_LOW))
                priority_low_reg <= reg_wdata[5:0];
            if (wr(`ADDR_PRIORITY_HIGH))
                priority_high_reg <= reg_wdata[5:0];
            if (wr(`ADDR_PRIORITY_AUX_LOW))
                priority_aux_low <= reg_wdata[4:0];
            if (wr(`ADDR_PRIORITY_AUX_HIGH))
                priority_aux_high <= reg_wdata[4:0];
            if (wr(`ADDR_SRC_MASK))
                src_mask <= {reg_wdata[2:0], reg_wdata};
        end
    end

    // Source vector in src_t order
    assign src_flags = {core_flags[5], aux_event_flags[`BIT_TOUCH_FLAG], aux_event_flags[`BIT_EXT2_FLAG],
                        aux_event_flags[`BIT_PORT1_FLAG], aux_event_flags[`BIT_RTC_FLAG], core_flags[4:0],
                        ext_pin0_event};

    always_comb
    begin
        src_enable = 11'h000;
        src_enable[irq_unit_pkg::SRC_TIMER2] = interrupt_enable_main[`BIT_TIMER2_EN];
        src_enable[irq_unit_pkg::SRC_SERIAL] = interrupt_enable_main[`BIT_SERIAL_EN];
        src_enable[irq_unit_pkg::SRC_TIMER1] = interrupt_enable_main[`BIT_TIMER1_EN];
        src_enable[irq_unit_pkg::SRC_TIMER0] = interrupt_enable_main[`BIT_TIMER0_EN];
        src_enable[irq_unit_pkg::SRC_EXT1] = interrupt_enable_main[`BIT_EXT1_EN];
        src_enable[irq_unit_pkg::SRC_EXT0] = interrupt_enable_main[`BIT_EXT0_EN];
        src_enable[irq_unit_pkg::SRC_SPI] = interrupt_enable_aux[`BIT_SPI_EN];
        src_enable[irq_unit_pkg::SRC_TOUCH] = interrupt_enable_aux[`BIT_TOUCH_EN];
        src_enable[irq_unit_pkg::SRC_PORT1] = interrupt_enable_aux[`BIT_PORT1_EN];
        src_enable[irq_unit_pkg::SRC_RTC] = interrupt_enable_aux[`BIT_RTC_EN];
        src_enable[irq_unit_pkg::SRC_EXT2] = interrupt_enable_aux[`BIT_EXT2_EN];
    end

    assign src_active = global_irq_enable ? (src_flags & src_enable) : 11'h000;

    // highest priority level, then lowest index
    always_comb
    begin
        next_request = 1'b0;
        next_source = 4'(irq_unit_pkg::SRC_NONE);
        next_priority = 2'h0;
        for (int lvl = 3; lvl >= 0; lvl--)
        begin
            for (int i = 10; i >= 0; i--)
            begin
                if (!next_request || next_priority == 2'(lvl))
                begin
                    if (src_active[i] && prio(5'(i)) == 2'(lvl) && !(next_request && next_priority > 2'(lvl)))
                    begin
                        next_request = 1'b1;
                        next_source = 4'(i);
                        next_priority = 2'(lvl);
                    end
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            irq_request <= 1'b0;
            irq_source <= 4'(irq_unit_pkg::SRC_NONE);
            irq_priority <= 2'h0;
        end
        else
        begin
            irq_request <= next_request;
            irq_source <= next_source;
            irq_priority <= next_priority;
        end
    end

    // Wake needs the pin enable only, not the global gate
    assign wake_cond = in_stop_mode &&
        ((ext_pin0_event && interrupt_enable_main[`BIT_EXT0_EN]) ||
         (ext_pin1_event && interrupt_enable_main[`BIT_EXT1_EN]) ||
         (event_set[`BIT_EXT2_FLAG] && interrupt_enable_aux[`BIT_EXT2_EN]) ||
         event_set[`BIT_PORT1_FLAG]);

    // Pin events are levels; one pulse per rise so a held pin wakes once
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wake_prev <= 1'b0;
            wake_request <= 1'b0;
        end
        else
        begin
            wake_prev <= wake_cond;
            wake_request <= wake_cond && !wake_prev;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            selfprog_write_unlock <= 1'b0;
            auto_touch_scan <= 1'b0;
        end
        else
        begin
            selfprog_write_unlock <= interrupt_enable_aux[`UNLOCK_HI:`UNLOCK_LO] == `UNLOCK_CODE;
            auto_touch_scan <= auto_touch_mode;
        end
    end

    // Sticky source pending, write one to clear, set wins
    assign src_set = src_flags & {11{1'b1}};
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            src_pending <= 11'h000;
        else if (wr(`ADDR_SRC_PENDING))
            src_pending <= (src_pending & ~{reg_wdata[2:0], reg_wdata}) | src_set;
        else
            src_pending <= src_pending | src_set;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(src_pending & src_mask);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_read)
        begin
            unique case (reg_addr)
                `ADDR_MISC_OPTION_CTRL: reg_rdata <= misc_option_ctrl;
                `ADDR_AUX_EVENT_FLAGS: reg_rdata <= {4'h0, aux_event_flags};
                `ADDR_PORT1_WAKE_ENABLE: reg_rdata <= port1_wake_enable;
                `ADDR_IRQ_ENABLE_MAIN: reg_rdata <= interrupt_enable_main;
                `ADDR_IRQ_ENABLE_AUX: reg_rdata <= interrupt_enable_aux;
                `ADDR_PRIORITY_LOW: reg_rdata <= {2'h0, priority_low_reg};
                `ADDR_PRIORITY_HIGH: reg_rdata <= {2'h0, priority_high_reg};
                `ADDR_PRIORITY_AUX_LOW: reg_rdata <= {3'h0, priority_aux_low};
                `ADDR_PRIORITY_AUX_HIGH: reg_rdata <= {3'h0, priority_aux_high};
                `ADDR_SRC_PENDING: reg_rdata <= src_pending[7:0];
                `ADDR_SRC_MASK: reg_rdata <= src_mask[7:0];
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end
endmodule : irq_flag_enable_wake_unit

// *** verif/irq_unit_asserts.sv ***
// Port-level checks for the interrupt flag and enable unit
`timescale 1ns/1ps
module irq_unit_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic in_stop_mode,
    input wire logic irq_request,
    input wire logic [3:0] irq_source,
    input wire logic wake_request,
    input wire logic selfprog_write_unlock,
    input wire logic auto_touch_scan
);
    logic [7:0] en_main;
    logic [7:0] en_aux;
    logic scan_on;
    logic no_en;
    // Shadows built from bus writes only, so the checker never trusts the design
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            en_main <= 8'h00;
            en_aux <= 8'h00;
            scan_on <= 1'b0;
        end
        else if (reg_write)
        begin
            if (reg_addr == 8'hA8)
                en_main <= reg_wdata;
            if (reg_addr == 8'hA9)
                en_aux <= reg_wdata;
            if (reg_addr == 8'h94)
                scan_on <= reg_wdata[5];
        end
    end
    assign no_en = en_main[5:0] == 6'h00 && en_aux[4:0] == 5'h00;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    chk_global_gate: assert property (!en_main[7] ##1 !en_main[7] |-> !irq_request)
        else $error("request raised with global enable off");
    chk_source_gate: assert property (no_en ##1 no_en |-> !irq_request)
        else $error("request raised with every source disabled");
    chk_req_source: assert property (irq_request |-> irq_source <= 4'hA)
        else $error("request names no valid source");
    chk_unlock_value: assert property (en_aux[7:5] == $past(en_aux[7:5])
        |-> selfprog_write_unlock == (en_aux[7:5] == 3'h5))
        else $error("write unlock does not follow the unlock field");
    chk_scan_mirror: assert property ($stable(scan_on) |-> auto_touch_scan == scan_on)
        else $error("auto scan output does not follow its bit");
    chk_wake_pulse: assert property (wake_request |=> !wake_request)
        else $error("wake request longer than one cycle");
    chk_wake_stop: assert property ($rose(wake_request)
        |-> $past(in_stop_mode) || $past(in_stop_mode, 2))
        else $error("wake request outside stop mode");
    chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside the read answer cycle");
    cover property (irq_request && en_aux[3]);
    cover property (wake_request);
    cover property (selfprog_write_unlock);
endmodule : irq_unit_asserts

bind irq_flag_enable_wake_unit irq_unit_asserts chk (.clock, .rst_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .in_stop_mode, .irq_request, .irq_source,
    .wake_request, .selfprog_write_unlock, .auto_touch_scan);

// *** verif/core_vector_model.sv ***
// Core side model: takes requests and answers with a vector entry
`timescale 1ns/1ps
module core_vector_model #(
    parameter int HOLDOFF = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic accept,
    input wire logic irq_request,
    input wire logic [3:0] irq_source,
    output logic vector_ack,
    output logic [3:0] vector_src
);
    int wait_cnt;
    always_ff @(posedge clock)
    begin
        vector_ack <= 1'b0;
        vector_src <= 4'hF;
        if (!rst_n)
            wait_cnt <= 0;
        else if (wait_cnt != 0)
            wait_cnt <= wait_cnt - 1;
        else if (accept && irq_request)
        begin
            vector_ack <= 1'b1;
            vector_src <= irq_source;
            // Request lags the flag clear by a cycle or two
            wait_cnt <= HOLDOFF;
        end
    end
endmodule : core_vector_model

// *** verif/tb_top.sv ***
// Register-level bench for the interrupt flag and enable unit
`timescale 1ns/1ps
module tb_top;
    logic clock, rst_n, reg_write, reg_read, touch_detect, ext_pin2, vector_ack, in_stop_mode;
    logic ext_pin0_event, ext_pin1_event, irq_request, wake_request, selfprog_write_unlock, auto_touch_scan, irq;
    logic accept;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port1_pins;
    logic [5:0] core_flags;
    logic [3:0] vector_src, irq_source;
    logic [1:0] irq_priority;
    int failures = 0;
    int checked = 0;
    int gap;
    logic [7:0] clr_code [4] = '{8'hFE, 8'hFB, 8'hFD, 8'hF7};
    logic [7:0] clr_left [4] = '{8'h0E, 8'h0A, 8'h08, 8'h00};
    logic [7:0] aux_en [3] = '{8'h08, 8'h04, 8'h02};
    logic [7:0] aux_src [3] = '{8'h09, 8'h08, 8'h07};
    logic [7:0] m_en [5] = '{8'h82, 8'h88, 8'h90, 8'hA0, 8'h80};
    logic [7:0] a_en [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10};
    logic [7:0] m_src [5] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h0A};
    logic [7:0] m_pri [5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h01};
    int cf_bit [5] = '{0, 2, 3, 4, 5};
    // Slow tick every second clock keeps timer events inside the run
    irq_flag_enable_wake_unit #(.SLOW_DIVIDE(2)) dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .touch_detect, .ext_pin2, .port1_pins, .core_flags, .vector_ack, .vector_src,
        .in_stop_mode, .ext_pin0_event, .ext_pin1_event, .irq_request, .irq_source,
        .irq_priority, .wake_request, .selfprog_write_unlock, .auto_touch_scan, .irq);
    core_vector_model core (.clock, .rst_n, .accept, .irq_request, .irq_source, .vector_ack,
        .vector_src);
    task automatic print_verdict();
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // A gap cycle after each strobe keeps one assignment per signal per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        @(posedge clock);
    endtask : rd
    function automatic logic pick(input int k);
        case (k)
            0: return irq_request;
            1: return wake_request;
            2: return irq;
            default: return selfprog_write_unlock;
        endcase
    endfunction : pick
    task automatic wait_on(input int k, input logic want);
        int n;
        n = 0;
        #1;
        while (pick(k) !== want)
        begin
            n++;
            if (n > 40)
            begin
                failures++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, pick(k), want);
                print_verdict();
            end
            @(posedge clock);
            #1;
        end
        @(posedge clock);
    endtask : wait_on
    task automatic fire(input int k);
        if (k == 0)
            touch_detect <= 1'b1;
        else if (k == 1)
            ext_pin2 <= 1'b0;
        else
            port1_pins <= ~port1_pins;
        repeat (2) @(posedge clock);
        touch_detect <= 1'b0;
        ext_pin2 <= 1'b1;
        @(posedge clock);
    endtask : fire
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial
    begin
        repeat (60000) @(posedge clock);
        failures++;
        print_verdict();
    end
    initial
    begin
        rst_n = 1'b0;
        {reg_addr, reg_wdata, reg_write, reg_read, touch_detect, in_stop_mode} = '0;
        {port1_pins, core_flags, ext_pin0_event, ext_pin1_event, accept} = '0;
        ext_pin2 = 1'b1;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(8'h94, 8'hC1);
        rd(8'h96, 8'h00);
        rd(8'h95, 8'h00);
        rd(8'hA8, 8'h00);
        rd(8'hA9, 8'h00);
        rd(8'h50, 8'h00);
        wr(8'h94, 8'hE1);
        fire(2);
        rd(8'h95, 8'h00);
        wr(8'h96, 8'h01);
        fire(0);
        fire(1);
        fire(2);
        rd(8'h95, 8'h0E);
        wr(8'h95, 8'h00);
        rd(8'h95, 8'h0E);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h95, clr_code[i]);
            rd(8'h95, clr_left[i]);
        end
        wr(8'hBA, 8'h1F);
        wr(8'hB9, 8'h3F);
        for (int i = 0; i < 3; i++)
        begin
            fire(i);
            wr(8'hA9, aux_en[i]);
            repeat (3) @(posedge clock);
            chk({7'h00, irq_request}, 8'h00);
            wr(8'hA8, 8'h80);
            wait_on(0, 1'b1);
            chk({4'h0, irq_source}, aux_src[i]);
            chk({6'h00, irq_priority}, 8'h01);
            accept <= 1'b1;
            wait_on(0, 1'b0);
            accept <= 1'b0;
            rd(8'h95, 8'h00);
            wr(8'hA8, 8'h00);
        end
        for (int j = 0; j < 5; j++)
        begin
            core_flags[cf_bit[j]] <= 1'b1;
            wr(8'hA9, a_en[j]);
            wr(8'hA8, m_en[j]);
            wait_on(0, 1'b1);
            chk({4'h0, irq_source}, m_src[j]);
            chk({6'h00, irq_priority}, m_pri[j]);
            core_flags <= 6'h00;
            wait_on(0, 1'b0);
        end
        in_stop_mode <= 1'b1;
        wr(8'hA9, 8'h00);
        wr(8'hA8, 8'h81);
        ext_pin0_event <= 1'b1;
        wait_on(1, 1'b1);
        ext_pin0_event <= 1'b0;
        wr(8'hA8, 8'h84);
        ext_pin1_event <= 1'b1;
        wait_on(1, 1'b1);
        ext_pin1_event <= 1'b0;
        wr(8'hA8, 8'h80);
        wr(8'hA9, 8'h04);
        ext_pin2 <= 1'b0;
        wait_on(1, 1'b1);
        ext_pin2 <= 1'b1;
        in_stop_mode <= 1'b0;
        wr(8'h95, 8'hFB);
        wr(8'hA9, 8'hE0);
        repeat (2) @(posedge clock);
        chk({7'h00, selfprog_write_unlock}, 8'h00);
        wr(8'hA9, 8'hA0);
        wait_on(3, 1'b1);
        wr(8'hA9, 8'h80);
        wait_on(3, 1'b0);
        rd(8'hA9, 8'h80);
        wr(8'hF0, 8'hFF);
        rd(8'hF0, 8'h00);
        wr(8'hF1, 8'hFF);
        core_flags[0] <= 1'b1;
        wr(8'hA8, 8'h82);
        wait_on(2, 1'b1);
        wr(8'hF1, 8'h00);
        wait_on(2, 1'b0);
        wr(8'hF1, 8'hFF);
        wait_on(2, 1'b1);
        core_flags <= 6'h00;
        wr(8'hA8, 8'h00);
        rd(8'hF0, 8'h02);
        wr(8'hF0, 8'hFF);
        wait_on(2, 1'b0);
        rd(8'hF0, 8'h00);
        // Rate code 11: one timer event per 8192 slow ticks, two clocks each
        wr(8'h94, 8'hE3);
        wr(8'hA9, 8'h01);
        wr(8'hA8, 8'h80);
        gap = 0;
        #1;
        while (irq_request !== 1'b1 && gap < 20000)
        begin
            @(posedge clock);
            #1;
            gap++;
        end
        chk({7'h00, irq_request}, 8'h01);
        @(posedge clock);
        wr(8'h95, 8'hFE);
        gap = 3;
        #1;
        while (irq_request !== 1'b1 && gap < 20000)
        begin
            @(posedge clock);
            #1;
            gap++;
        end
        chk(8'(gap >> 8), 8'h40);
        chk(8'(gap), 8'h00);
        @(posedge clock);
        print_verdict();
    end
endmodule : tb_top
